// ==== verilog/status_reporting_defines.svh ====
// Summary of operation
// RULE_01: Frequency sub-register bit 8 is set while an external reference is in use.
// RULE_02: Limit sub-register bit 0 flags limit line one, bit 1 limit line two.
// RULE_03: Overload sub-register bit 2 follows IF overload, with the overrange indication.
// RULE_04: Bit 15 of frequency, limit and overload registers always reads zero; the code reads it as one in the positive filter parts after preset.
// RULE_05: Service request when status byte bits 2,3,4,5,7 are set and enabled.
// RULE_06: Event enable bit 0 is operation complete; service enable 32 enables bit 5.
// RULE_07: Serial poll returns the status byte, same value as the status byte query.
// RULE_08: Every register part query returns its plain bit pattern as one number.
// RULE_09: Each error appends one queue entry; each query pops one; empty returns 0; the code drops an error pushed while the queue holds 8 entries.
// RULE_10: Status byte and event status cleared at power-on with clear flag, and clear-status; the code loads event status with bit 7 set at power-on.
// RULE_11: Service, event and parallel poll enables cleared only at power-on with clear flag.
// RULE_12: All event parts cleared at power-on with clear flag and by clear-status.
// RULE_13: Power-on with clear flag or preset clears questionable enable parts.
// RULE_14: Power-on with clear flag or preset sets positive filters, clears negative filters.
// RULE_15: Command processing and input buffer cleared at every power-on and device clear.
// RULE_16: Output buffer cleared at power-on, device clear and first command of a message.
// RULE_17: Device clear and status resets leave instrument settings untouched.
// RULE_18: Reading an event part returns it and clears it in the same read.
// RULE_19: An enabled event bit raises the summary bit at the next level.
// RULE_20: Filter-selected condition transitions write a one into the event bit.
// RULE_21: Preset loads positive filters with all sixteen ones.
// RULE_22: Each sub-register has condition, event, enable, two filters and feeds the parent.
`ifndef STATUS_REPORTING_DEFINES_SVH
`define STATUS_REPORTING_DEFINES_SVH

// Sub-register select codes
`define SEL_FREQ 2'h0
`define SEL_LIMIT 2'h1
`define SEL_POWER 2'h2
`define SEL_QUEST 2'h3

// Bit positions inside the sub-registers
`define FREQ_EXTREF_BIT 8
`define LIMIT_LINE1_BIT 0
`define LIMIT_LINE2_BIT 1
`define POWER_OVERRANGE_INDICATION_BIT 2
`define QUEST_BATTERY_BIT 2
`define QUEST_POWER_BIT 3
`define QUEST_TEMP_BIT 4
`define QUEST_FREQ_BIT 5
`define QUEST_LIMIT_BIT 9
`define QUEST_CAL_BIT 10

// Status byte bits
`define STB_ERRQ_BIT 2
`define STB_QUEST_BIT 3
`define STB_MAV_BIT 4
`define STB_ESB_BIT 5
`define STB_MSS_BIT 6
`define STB_OPER_BIT 7
`define STB_SRQ_MASK 8'hbc

// Event status register bits
`define ESR_POWERON 8'h80

// Reset and preset values
`define REG_VALID_MASK 16'h7fff
`define PTR_PRESET 16'hffff
`define NTR_PRESET 16'h0000
`define ENA_PRESET 16'h0000

// Error queue
`define ERRQ_DEPTH 8
`define ERRQ_PTR_W 3
`define ERRQ_NO_ERROR 16'h0000

`endif

// ==== verilog/status_reporting_pkg.sv ====
package status_reporting_pkg;

  // Commands accepted on the command port
  typedef enum logic [4:0] {
    CMD_NOP,
    CMD_READ_EVENT,
    CMD_READ_COND,
    CMD_READ_ENABLE,
    CMD_READ_PTR,
    CMD_READ_NTR,
    CMD_WRITE_ENABLE,
    CMD_WRITE_PTR,
    CMD_WRITE_NTR,
    CMD_READ_STB,
    CMD_READ_SRE,
    CMD_WRITE_SRE,
    CMD_READ_ESE,
    CMD_WRITE_ESE,
    CMD_READ_ESR,
    CMD_READ_PPE,
    CMD_WRITE_PPE,
    CMD_CLEAR_STATUS,
    CMD_STATUS_PRESET,
    CMD_ERROR_QUERY
  } cmd_op_t;

endpackage : status_reporting_pkg

// ==== verilog/status_reporting_regs.sv ====
`timescale 1ns/1ps
`include "status_reporting_defines.svh"

module status_reporting_regs (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic powerOnClear,
  input wire logic cmdValid,
  input wire status_reporting_pkg::cmd_op_t cmdOp,
  input wire logic [1:0] cmdSel,
  input wire logic [15:0] cmdData,
  input wire logic msgStart,
  input wire logic devClear,
  input wire logic pollReq,
  input wire logic extRefInUse,
  input wire logic limit1Fail,
  input wire logic limit2Fail,
  input wire logic ifOverload,
  input wire logic batteryLow,
  input wire logic tempQuestionable,
  input wire logic calUnaligned,
  input wire logic operSummary,
  input wire logic msgAvailable,
  input wire logic [7:0] esrEvents,
  input wire logic errPush,
  input wire logic [15:0] errCode,
  output logic respValid,
  output logic [15:0] respData,
  output logic pollValid,
  output logic [7:0] pollData,
  output logic srq,
  output logic overrangeIndication,
  output logic outBufClear,
  output logic inBufClear
);
  import status_reporting_pkg::*;

  // Sub-register select match used by writes and event reads; the read mux indexes by cmdSel directly
  function automatic logic regHit(input logic [1:0] sel, input logic [1:0] idx);
    regHit = (sel == idx);
  endfunction : regHit

  logic [3:0][15:0] condIn;
  logic [3:0][15:0] condAll;
  logic [3:0][15:0] evtAll;
  logic [3:0][15:0] enaAll;
  logic [3:0][15:0] ptrAll;
  logic [3:0][15:0] ntrAll;
  logic [3:0] summ;
  logic [7:0] sre;
  logic [7:0] ese;
  logic [7:0] ppe;
  logic [7:0] esr;
  logic [7:0] stb;
  logic [7:0] stbLow;
  logic [15:0] errMem [`ERRQ_DEPTH];
  logic [`ERRQ_PTR_W-1:0] rdPtr;
  logic [`ERRQ_PTR_W-1:0] wrPtr;
  logic [`ERRQ_PTR_W:0] errCount;

  // Command decode
  wire clsCmd = cmdValid && (cmdOp == CMD_CLEAR_STATUS);
  wire presetCmd = cmdValid && (cmdOp == CMD_STATUS_PRESET);
  wire wrEna = cmdValid && (cmdOp == CMD_WRITE_ENABLE);
  wire wrPtr_ = cmdValid && (cmdOp == CMD_WRITE_PTR);
  wire wrNtr = cmdValid && (cmdOp == CMD_WRITE_NTR);
  wire rdEvt = cmdValid && (cmdOp == CMD_READ_EVENT);
  wire rdEsr = cmdValid && (cmdOp == CMD_READ_ESR);
  wire errQuery = cmdValid && (cmdOp == CMD_ERROR_QUERY);
  wire isQuery = cmdValid && (cmdOp inside {CMD_READ_EVENT, CMD_READ_COND, CMD_READ_ENABLE,
    CMD_READ_PTR, CMD_READ_NTR, CMD_READ_STB, CMD_READ_SRE, CMD_READ_ESE, CMD_READ_ESR,
    CMD_READ_PPE, CMD_ERROR_QUERY});

  // Condition sources; bit 15 is never driven so it stays zero
  assign condIn[0] = 16'(extRefInUse) << `FREQ_EXTREF_BIT; // RULE_01
  assign condIn[1] = (16'(limit1Fail) << `LIMIT_LINE1_BIT)
                   | (16'(limit2Fail) << `LIMIT_LINE2_BIT); // RULE_02
  assign condIn[2] = 16'(ifOverload) << `POWER_OVERRANGE_INDICATION_BIT; // RULE_03
  assign condIn[3] = (16'(batteryLow) << `QUEST_BATTERY_BIT)
                   | (16'(summ[2]) << `QUEST_POWER_BIT)
                   | (16'(tempQuestionable) << `QUEST_TEMP_BIT)
                   | (16'(summ[0]) << `QUEST_FREQ_BIT)
                   | (16'(summ[1]) << `QUEST_LIMIT_BIT)
                   | (16'(calUnaligned) << `QUEST_CAL_BIT); // RULE_22

  // One generate slice per sub-register: frequency, limit, overload, questionable
  for (genvar i = 0; i < 4; i++) begin : gen_sub
    logic [15:0] cond;
    logic [15:0] evt;
    logic [15:0] ena;
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic hit;
    logic [15:0] setBits;
    logic [15:0] next_evt;

    assign hit = regHit(cmdSel, 2'(i));
    // Rising edges through the positive filter, falling through the negative
    assign setBits = ((condIn[i] & ~cond & ptr) | (~condIn[i] & cond & ntr)) & `REG_VALID_MASK; // RULE_20
    // Set wins over a read or clear-status in the same cycle
    assign next_evt = ((rdEvt && hit) || clsCmd ? 16'h0000 : evt) | setBits; // RULE_18 RULE_12

    // Condition, event and filter state
    always_ff @(posedge sys_clk) begin
      if (!nrst) begin
        cond <= 16'h0000;
        if (powerOnClear) begin
          evt <= 16'h0000; // RULE_12
          ena <= `ENA_PRESET; // RULE_13
          ptr <= `PTR_PRESET; // RULE_14
          ntr <= `NTR_PRESET; // RULE_14
        end
      end else begin
        cond <= condIn[i] & `REG_VALID_MASK; // RULE_04
        evt <= next_evt;
        if (presetCmd) begin
          ena <= `ENA_PRESET; // RULE_13
          ptr <= `PTR_PRESET; // RULE_21
          ntr <= `NTR_PRESET; // RULE_14
        end else begin
          if (wrEna && hit) ena <= cmdData & `REG_VALID_MASK;
          if (wrPtr_ && hit) ptr <= cmdData & `REG_VALID_MASK;
          if (wrNtr && hit) ntr <= cmdData & `REG_VALID_MASK;
        end
      end
    end

    assign summ[i] = |(evt & ena); // RULE_19
    assign condAll[i] = cond;
    assign evtAll[i] = evt;
    assign enaAll[i] = ena;
    assign ptrAll[i] = ptr;
    assign ntrAll[i] = ntr;
  end

  // Status byte is built from live sources; clearing those clears it
  assign stbLow[`STB_ERRQ_BIT] = (errCount != '0);
  assign stbLow[`STB_QUEST_BIT] = summ[3];
  assign stbLow[`STB_MAV_BIT] = msgAvailable;
  assign stbLow[`STB_ESB_BIT] = |(esr & ese); // RULE_06
  assign stbLow[`STB_OPER_BIT] = operSummary;
  assign stbLow[`STB_MSS_BIT] = 1'b0;
  assign stbLow[1:0] = 2'b00;
  wire srqNext = |(stbLow & sre & `STB_SRQ_MASK); // RULE_05
  assign stb = stbLow | (8'(srqNext) << `STB_MSS_BIT);

  // Common status registers; devClear touches none of them
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      if (powerOnClear) begin
        esr <= `ESR_POWERON; // RULE_10
        sre <= 8'h00; // RULE_11
        ese <= 8'h00; // RULE_11
        ppe <= 8'h00; // RULE_11
      end else begin
        esr <= esr | `ESR_POWERON;
      end
    end else begin
      esr <= (rdEsr || clsCmd ? 8'h00 : esr) | esrEvents; // RULE_10 RULE_18
      if (cmdValid && cmdOp == CMD_WRITE_SRE) sre <= cmdData[7:0]; // RULE_06
      if (cmdValid && cmdOp == CMD_WRITE_ESE) ese <= cmdData[7:0]; // RULE_06
      if (cmdValid && cmdOp == CMD_WRITE_PPE) ppe <= cmdData[7:0];
    end
  end

  // Error queue; a push into a full queue is dropped to keep the oldest causes
  wire errPop = errQuery && (errCount != '0);
  wire errFull = (errCount == (`ERRQ_PTR_W+1)'(`ERRQ_DEPTH));
  wire errWr = errPush && !errFull;
  always_ff @(posedge sys_clk) begin
    if (!nrst || clsCmd) begin
      rdPtr <= '0;
      wrPtr <= '0;
      errCount <= '0;
    end else begin
      if (errWr) begin
        errMem[wrPtr] <= errCode; // RULE_09
        wrPtr <= wrPtr + 1'b1;
      end
      if (errPop) rdPtr <= rdPtr + 1'b1; // RULE_09
      errCount <= errCount + (`ERRQ_PTR_W+1)'(errWr) - (`ERRQ_PTR_W+1)'(errPop);
    end
  end

  // Query answer selection
  logic [15:0] readMux;
  always_comb begin
    readMux = 16'h0000;
    unique case (cmdOp)
      CMD_READ_EVENT: readMux = evtAll[cmdSel]; // RULE_08
      CMD_READ_COND: readMux = condAll[cmdSel]; // RULE_08
      CMD_READ_ENABLE: readMux = enaAll[cmdSel];
      CMD_READ_PTR: readMux = ptrAll[cmdSel];
      CMD_READ_NTR: readMux = ntrAll[cmdSel];
      CMD_READ_STB: readMux = {8'h00, stb}; // RULE_07
      CMD_READ_SRE: readMux = {8'h00, sre};
      CMD_READ_ESE: readMux = {8'h00, ese};
      CMD_READ_ESR: readMux = {8'h00, esr};
      CMD_READ_PPE: readMux = {8'h00, ppe};
      CMD_ERROR_QUERY: readMux = (errCount != '0) ? errMem[rdPtr] : `ERRQ_NO_ERROR; // RULE_09
      default: readMux = 16'h0000;
    endcase
  end

  // Registered outputs; buffer clears pulse and never touch instrument settings
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      respValid <= 1'b0;
      respData <= 16'h0000;
      pollValid <= 1'b0;
      pollData <= 8'h00;
      srq <= 1'b0;
      overrangeIndication <= 1'b0;
      outBufClear <= 1'b1; // RULE_16
      inBufClear <= 1'b1; // RULE_15
    end else begin
      respValid <= isQuery;
      respData <= isQuery ? readMux : 16'h0000;
      pollValid <= pollReq;
      pollData <= pollReq ? stb : 8'h00; // RULE_07
      srq <= srqNext; // RULE_05
      overrangeIndication <= ifOverload; // RULE_03
      outBufClear <= devClear || (cmdValid && msgStart); // RULE_16 RULE_17
      inBufClear <= devClear; // RULE_15 RULE_17
    end
  end

endmodule : status_reporting_regs

// ==== dv/remote_ctrl_model.sv ====
`timescale 1ns/1ps
// Controller side of the command port: one command per call, answer sampled one edge later
module remote_ctrl_model (
  input wire logic sys_clk,
  output logic cmdValid,
  output status_reporting_pkg::cmd_op_t cmdOp,
  output logic [1:0] cmdSel,
  output logic [15:0] cmdData,
  input wire logic respValid,
  input wire logic [15:0] respData
);
  import status_reporting_pkg::*;
  // Idle port at time zero
  initial begin
    cmdValid = 1'b0;
    cmdOp = CMD_NOP;
    cmdSel = 2'h0;
    cmdData = 16'h0000;
  end
  // Released data is inverted so a stale value never looks valid
  task automatic xfer(input cmd_op_t op, input logic [1:0] sel, input logic [15:0] data, output logic [15:0] got);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdSel <= sel;
    cmdData <= data;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    cmdOp <= CMD_NOP;
    cmdData <= ~data;
    #1;
    got = respValid ? respData : 16'hdead;
    // Return on an edge so the caller's next drive lands on the rising edge
    @(posedge sys_clk);
  endtask : xfer
endmodule : remote_ctrl_model

// ==== dv/status_reporting_checker.sv ====
`timescale 1ns/1ps
// Port-level timing checks of the status block
module status_reporting_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire status_reporting_pkg::cmd_op_t cmdOp,
  input wire logic msgStart,
  input wire logic devClear,
  input wire logic pollReq,
  input wire logic ifOverload,
  input wire logic respValid,
  input wire logic [15:0] respData,
  input wire logic pollValid,
  input wire logic overrangeIndication,
  input wire logic outBufClear,
  input wire logic inBufClear
);
  import status_reporting_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Opcode classes: every query answers, condition and event parts keep the top bit clear
  wire isQry = cmdOp inside {CMD_READ_EVENT, CMD_READ_COND, CMD_READ_ENABLE, CMD_READ_PTR, CMD_READ_NTR,
    CMD_READ_STB, CMD_READ_SRE, CMD_READ_ESE, CMD_READ_ESR, CMD_READ_PPE, CMD_ERROR_QUERY};
  wire isPart = cmdOp inside {CMD_READ_EVENT, CMD_READ_COND};
  sequence s_qry;
    cmdValid && isQry;
  endsequence
  sequence s_first;
    cmdValid && msgStart;
  endsequence
  property p_ans;
    s_qry |=> respValid;
  endproperty
  property p_quiet;
    !(cmdValid && isQry) |=> !respValid;
  endproperty
  property p_top;
    respValid && $past(cmdValid && isPart) |-> !respData[15];
  endproperty
  property p_ovl;
    ifOverload |=> overrangeIndication;
  endproperty
  property p_novl;
    overrangeIndication |-> $past(ifOverload);
  endproperty
  property p_poll;
    pollReq |=> pollValid;
  endproperty
  property p_dcl;
    devClear |=> outBufClear && inBufClear;
  endproperty
  property p_obc;
    s_first |=> outBufClear;
  endproperty
  property p_idle;
    !devClear && !(cmdValid && msgStart) |=> !outBufClear && !inBufClear;
  endproperty
  a_ans: assert property (p_ans) else $error("query not answered");
  a_quiet: assert property (p_quiet) else $error("answer without query");
  a_top: assert property (p_top) else $error("top bit set");
  a_ovl: assert property (p_ovl) else $error("overrange missing");
  a_novl: assert property (p_novl) else $error("overrange spurious");
  a_poll: assert property (p_poll) else $error("poll not answered");
  a_dcl: assert property (p_dcl) else $error("device clear missed");
  a_obc: assert property (p_obc) else $error("output buffer kept");
  a_idle: assert property (p_idle) else $error("buffer clear spurious");
endmodule : status_reporting_checker

bind status_reporting_regs status_reporting_checker u_status_reporting_checker (.sys_clk, .nrst, .cmdValid,
  .cmdOp, .msgStart, .devClear, .pollReq, .ifOverload, .respValid, .respData, .pollValid,
  .overrangeIndication, .outBufClear, .inBufClear);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import status_reporting_pkg::*;
  logic sys_clk, nrst, powerOnClear, msgStart, devClear, pollReq, errPush;
  logic extRefInUse, limit1Fail, limit2Fail, ifOverload, cmdValid, respValid, pollValid;
  logic srq, overrangeIndication, outBufClear, inBufClear;
  logic [1:0] cmdSel;
  logic [7:0] esrEvents, pollData;
  logic [15:0] cmdData, respData, errCode, got;
  cmd_op_t cmdOp;
  int errorCnt = 0;
  int nChecks = 0;
  logic [15:0] cexp [3] = '{16'h0100, 16'h0003, 16'h0004};
  // Unused status sources are tied low
  status_reporting_regs u_status_reporting_regs (.sys_clk, .nrst, .powerOnClear, .cmdValid, .cmdOp, .cmdSel,
    .cmdData, .msgStart, .devClear, .pollReq, .extRefInUse, .limit1Fail, .limit2Fail, .ifOverload,
    .batteryLow(1'b0), .tempQuestionable(1'b0), .calUnaligned(1'b0), .operSummary(1'b0), .msgAvailable(1'b0),
    .esrEvents, .errPush, .errCode, .respValid, .respData, .pollValid, .pollData, .srq, .overrangeIndication,
    .outBufClear, .inBufClear);
  remote_ctrl_model u_remote_ctrl_model (.sys_clk, .cmdValid, .cmdOp, .cmdSel, .cmdData, .respValid, .respData);
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    nChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic q(input cmd_op_t op, input logic [1:0] s, input logic [15:0] e);
    u_remote_ctrl_model.xfer(op, s, 16'h0000, got);
    chk(got, e);
  endtask : q
  task automatic w(input cmd_op_t op, input logic [1:0] s, input logic [15:0] d);
    u_remote_ctrl_model.xfer(op, s, d, got);
  endtask : w
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // Enables cleared, rising filters all sixteen ones, falling filters cleared
  task automatic presetChk();
    for (int i = 0; i < 4; i++) begin
      q(CMD_READ_ENABLE, i[1:0], 16'h0000);
      q(CMD_READ_NTR, i[1:0], 16'h0000);
      q(CMD_READ_PTR, i[1:0], 16'hffff);
    end
  endtask : presetChk
  // Hang guard
  initial begin
    tick(20000);
    errorCnt++;
    end_of_test();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    powerOnClear = 1'b1;
    {msgStart, devClear, pollReq, errPush, extRefInUse, limit1Fail, limit2Fail, ifOverload} = 8'h00;
    esrEvents = 8'h00;
    errCode = 16'h0000;
    tick(20);
    nrst <= 1'b1;
    presetChk();
    q(CMD_READ_SRE, 0, 16'h0000);
    q(CMD_READ_ESE, 0, 16'h0000);
    q(CMD_READ_PPE, 0, 16'h0000);
    q(CMD_READ_ESR, 0, 16'h0080);
    q(CMD_READ_ESR, 0, 16'h0000);
    // Rising conditions seen in condition and event parts; event read clears
    {extRefInUse, limit1Fail, limit2Fail, ifOverload} <= 4'hf;
    tick(3);
    for (int i = 0; i < 3; i++) begin
      q(CMD_READ_COND, i[1:0], cexp[i]);
      q(CMD_READ_EVENT, i[1:0], cexp[i]);
      q(CMD_READ_EVENT, i[1:0], 16'h0000);
    end
    // Falling edge caught only through the negative filter; clear-status wipes events
    w(CMD_WRITE_NTR, 1, 16'h0003);
    limit1Fail <= 1'b0;
    tick(3);
    q(CMD_READ_EVENT, 1, 16'h0001);
    limit2Fail <= 1'b0;
    tick(3);
    w(CMD_CLEAR_STATUS, 0, 16'h0000);
    q(CMD_READ_EVENT, 1, 16'h0000);
    w(CMD_WRITE_ENABLE, 2, 16'h0004);
    w(CMD_STATUS_PRESET, 0, 16'h0000);
    presetChk();
    // Operation complete through the event status byte to a service request
    w(CMD_WRITE_ESE, 0, 16'h0001);
    w(CMD_WRITE_SRE, 0, 16'h0020);
    esrEvents <= 8'h01;
    tick(1);
    esrEvents <= 8'h00;
    tick(3);
    #1;
    chk({15'h0, srq}, 16'h0001);
    q(CMD_READ_STB, 0, 16'h0060);
    pollReq <= 1'b1;
    tick(1);
    pollReq <= 1'b0;
    #1;
    chk({7'h0, pollValid, pollData}, 16'h0160);
    q(CMD_READ_ESR, 0, 16'h0001);
    tick(3);
    #1;
    chk({15'h0, srq}, 16'h0000);
    // Limit violation climbs to the questionable summary and the status byte
    w(CMD_WRITE_ENABLE, 1, 16'h0001);
    w(CMD_WRITE_ENABLE, 3, 16'h0200);
    w(CMD_WRITE_SRE, 0, 16'h0008);
    limit1Fail <= 1'b1;
    tick(6);
    #1;
    chk({15'h0, srq}, 16'h0001);
    q(CMD_READ_STB, 0, 16'h0048);
    // Error queue: oldest first, then the no-error code
    errCode <= 16'h0011;
    errPush <= 1'b1;
    tick(1);
    errCode <= 16'h0022;
    tick(1);
    errPush <= 1'b0;
    q(CMD_ERROR_QUERY, 0, 16'h0011);
    q(CMD_ERROR_QUERY, 0, 16'h0022);
    q(CMD_ERROR_QUERY, 0, 16'h0000);
    // Device clear empties buffers but keeps the enables
    devClear <= 1'b1;
    tick(1);
    devClear <= 1'b0;
    #1;
    chk({14'h0, outBufClear, inBufClear}, 16'h0003);
    q(CMD_READ_SRE, 0, 16'h0008);
    msgStart <= 1'b1;
    q(CMD_READ_PPE, 0, 16'h0000);
    msgStart <= 1'b0;
    end_of_test();
  end
endmodule : tb_top
